// >>> hw/idc_data_cmd.sv
`timescale 1ns/10ps

// What this block does
// RULE1: Reading the data byte field pops the next byte received from the bus.
// RULE2: Every data/command write queues one command; its direction bit marks write or read. Writes that raise transmit abort are not queued.
// RULE3: As master, direction 0 writes the byte, direction 1 reads one byte.
// RULE4: As slave receiver, the direction bit of queued entries is ignored.
// RULE5: As slave transmitter, a direction-0 entry sends its byte to the master.
// RULE6: A read queued after general call with general call enabled raises transmit abort.
// RULE7: Direction 1 written in answer to a slave read request raises transmit abort.
// RULE8: The stop bit ends the transfer after that byte.
// RULE9: SCL high count is 14 bits, core clock cycles, reset value 400.
// RULE10: High count writes take effect only while the interface is disabled.
// RULE11: High count values below 6 are stored as 6.
// RULE12: Software sets the high count first, low byte before high byte on narrow buses.
// RULE13: General call enable selects general call or start byte instead of addressed transfer.
// RULE14: Reserved bits ignore writes and read as zero.
module idc_data_cmd #(
	parameter int QUEUE_DEPTH = idc_pkg::IDC_QUEUE_DEPTH
) (
	// Peripheral clock and reset
	input  wire logic                              clk_in,
	input  wire logic                              nrst_in,
	// Peripheral register port (APB style)
	input  wire logic                              psel_in,
	input  wire logic                              penable_in,
	input  wire logic                              pwrite_in,
	input  wire logic [idc_pkg::IDC_ADDR_W-1:0]    paddr_in,
	input  wire logic [31:0]                       pwdata_in,
	output logic      [31:0]                       prdata_out,
	output logic                                   pready_out,
	output logic                                   pslverr_out,
	// Control and status from neighbouring registers
	input  wire logic                              iface_enable_in,
	input  wire logic                              general_call_enable_in,
	input  wire logic                              general_call_sent_in,
	input  wire logic                              master_mode_in,
	input  wire logic                              slave_transmit_in,
	input  wire logic                              slave_read_request_flag_in,
	output logic                                   transmit_abort_flag_out,
	output logic                                   rx_byte_ready_out,
	// Core clock side toward the bus engine
	input  wire logic                              core_clk_in,
	output logic                                   cmd_valid_out,
	output idc_pkg::idc_cmd_t                      cmd_out,
	input  wire logic                              cmd_ready_in,
	input  wire logic                              rx_valid_in,
	input  wire logic [7:0]                        rx_data_in,
	output logic                                   rx_ready_out,
	output logic      [idc_pkg::IDC_HCNT_W-1:0]    scl_high_count_out
);

	import idc_pkg::*;

	// ------------------------------------------------------------
	// Register port decode
	// ------------------------------------------------------------
	logic                  pready_q;
	logic [31:0]           prdata_q;
	logic                  pslverr_q;
	logic [IDC_HCNT_W-1:0] hcnt_q;
	logic                  stop_rb_q;
	logic [7:0]            rx_byte_q;
	logic                  rx_full_q;
	logic                  abort_q;
	logic                  q_s_ready;

	wire access     = psel_in && penable_in && !pready_q;
	wire hit_data   = (paddr_in == IDC_OFS_DATA_CMD);
	wire hit_hcnt   = (paddr_in == IDC_OFS_SCL_HIGH);
	wire hit_any    = hit_data || hit_hcnt;
	wire wr_data    = access && pwrite_in && hit_data;
	wire rd_data    = access && !pwrite_in && hit_data;
	wire wr_hcnt    = access && pwrite_in && hit_hcnt;

	// Incoming command fields; only bits 9:0 are looked at
	wire       in_dir  = pwdata_in[IDC_DIR_BIT];
	wire       in_stop = pwdata_in[IDC_STOP_BIT];
	wire [7:0] in_byte = pwdata_in[IDC_DATA_MSB:IDC_DATA_LSB]; // RULE14

	// ------------------------------------------------------------
	// Command qualification
	// ------------------------------------------------------------
	// A read after a general call is only legal once enable is cleared
	wire gc_read_abort  = in_dir && general_call_sent_in && general_call_enable_in; // RULE6 RULE13
	// A read command cannot answer a slave read request
	wire rrq_read_abort = in_dir && slave_read_request_flag_in; // RULE7
	wire cmd_abort      = gc_read_abort || rrq_read_abort;
	// Slaves do not steer direction, so only the master keeps the bit
	wire eff_dir        = master_mode_in ? in_dir : IDC_DIR_WRITE; // RULE3 RULE4 RULE5

	// Write stalls with pready low while the queue is full
	wire q_push     = wr_data && !cmd_abort && q_s_ready; // RULE2
	wire data_done  = !wr_data || cmd_abort || q_s_ready;
	wire done       = access && (!hit_data || data_done);

	idc_cmd_t q_in;
	assign q_in.stop = in_stop; // RULE8
	assign q_in.dir  = eff_dir; // RULE2
	assign q_in.data = in_byte;

	// Clamp and gate of the SCL high count
	wire [IDC_HCNT_W-1:0] hcnt_wr  = pwdata_in[IDC_HCNT_W-1:0];
	wire [IDC_HCNT_W-1:0] hcnt_lim = (hcnt_wr < IDC_HCNT_MIN) ? IDC_HCNT_MIN : hcnt_wr; // RULE11
	wire                  hcnt_we  = wr_hcnt && !iface_enable_in; // RULE10

	// Read mux, reserved bits zero
	wire [31:0] rd_mux = hit_data ? {22'h000000, stop_rb_q, 1'b0, rx_byte_q} : // RULE1 RULE14
	                     hit_hcnt ? {18'h00000, hcnt_q} : 32'h00000000; // RULE9 RULE14

	assign prdata_out              = prdata_q;
	assign pready_out              = pready_q;
	assign pslverr_out             = pslverr_q;
	assign transmit_abort_flag_out = abort_q;
	assign rx_byte_ready_out       = rx_full_q;

	// ------------------------------------------------------------
	// Bus answer registers
	// ------------------------------------------------------------
	// One wait state on every access; longer while the queue is full
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pready_q  <= 1'b0;
			prdata_q  <= 32'h00000000;
			pslverr_q <= 1'b0;
		end else begin
			pready_q  <= done;
			prdata_q  <= (done && !pwrite_in) ? rd_mux : 32'h00000000;
			pslverr_q <= done && !hit_any;
		end
	end

	// Programmable registers
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			hcnt_q    <= IDC_HCNT_RESET; // RULE9
			stop_rb_q <= 1'b0;
		end else begin
			if (hcnt_we) hcnt_q <= hcnt_lim; // RULE10 RULE11
			if (q_push)  stop_rb_q <= in_stop;
		end
	end

	// Abort event toward raw interrupt status bit 6, one-cycle pulse
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			abort_q <= 1'b0;
		end else begin
			abort_q <= wr_data && cmd_abort; // RULE6 RULE7
		end
	end

	// ------------------------------------------------------------
	// Transmit queue
	// ------------------------------------------------------------
	logic           q_m_valid;
	logic [IDC_CMD_W-1:0] q_m_data;
	logic           q_m_ready;

	idc_fifo #(
		.WIDTH (IDC_CMD_W),
		.DEPTH (QUEUE_DEPTH)
	) u_queue (
		.clk_in      (clk_in),
		.nrst_in     (nrst_in),
		.s_valid_in  (q_push),
		.s_data_in   (q_in),
		.s_ready_out (q_s_ready),
		.m_valid_out (q_m_valid),
		.m_data_out  (q_m_data),
		.m_ready_in  (q_m_ready)
	);

	// ------------------------------------------------------------
	// Command crossing, peripheral side (toggle handshake)
	// ------------------------------------------------------------
	idc_xfer_state_t xf_q;
	idc_xfer_state_t xf_d;
	idc_cmd_t        xfer_q;
	logic            req_tgl_q;
	logic            ack_s1_q;
	logic            ack_s2_q;
	logic            ack_s3_q;
	logic            ack_tgl_q;

	wire ack_seen = ack_s2_q ^ ack_s3_q;
	wire take     = (xf_q == IDC_XF_IDLE) && q_m_valid;
	assign q_m_ready = (xf_q == IDC_XF_IDLE);

	// Holding word must stay still until the core side answers
	always_comb begin
		xf_d = xf_q;
		unique case (xf_q)
			IDC_XF_IDLE: if (q_m_valid) xf_d = IDC_XF_WAIT;
			IDC_XF_WAIT: if (ack_seen)  xf_d = IDC_XF_IDLE;
			default:                    xf_d = IDC_XF_IDLE;
		endcase
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			xf_q      <= IDC_XF_IDLE;
			xfer_q    <= '0;
			req_tgl_q <= 1'b0;
		end else begin
			xf_q <= xf_d;
			if (take) begin
				xfer_q    <= idc_cmd_t'(q_m_data);
				req_tgl_q <= ~req_tgl_q;
			end
		end
	end

	// Acknowledge toggle brought back from the core clock
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ack_s1_q <= 1'b0;
			ack_s2_q <= 1'b0;
			ack_s3_q <= 1'b0;
		end else begin
			ack_s1_q <= ack_tgl_q;
			ack_s2_q <= ack_s1_q;
			ack_s3_q <= ack_s2_q;
		end
	end

	// ------------------------------------------------------------
	// Command crossing, core side
	// ------------------------------------------------------------
	logic     req_s1_q;
	logic     req_s2_q;
	logic     req_s3_q;
	logic     cmd_valid_q;
	idc_cmd_t cmd_q;

	wire req_seen = req_s2_q ^ req_s3_q;
	wire cmd_done = cmd_valid_q && cmd_ready_in;

	assign cmd_valid_out = cmd_valid_q;
	assign cmd_out       = cmd_q;

	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			req_s1_q <= 1'b0;
			req_s2_q <= 1'b0;
			req_s3_q <= 1'b0;
		end else begin
			req_s1_q <= req_tgl_q;
			req_s2_q <= req_s1_q;
			req_s3_q <= req_s2_q;
		end
	end

	// Word is stable by the time the request edge is seen here
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cmd_valid_q <= 1'b0;
			cmd_q       <= '0;
			ack_tgl_q   <= 1'b0;
		end else begin
			if (req_seen) begin
				cmd_valid_q <= 1'b1; // RULE2
				cmd_q       <= xfer_q; // RULE3 RULE5 RULE8
			end else if (cmd_done) begin
				cmd_valid_q <= 1'b0;
				ack_tgl_q   <= ~ack_tgl_q;
			end
		end
	end

	// ------------------------------------------------------------
	// Received byte crossing
	// ------------------------------------------------------------
	logic       rx_busy_q;
	logic [7:0] rx_hold_q;
	logic       rx_tgl_q;
	logic       rxa_s1_q;
	logic       rxa_s2_q;
	logic       rxa_s3_q;
	logic       rx_s1_q;
	logic       rx_s2_q;
	logic       rx_s3_q;
	logic       rx_ack_tgl_q;

	wire rx_take    = rx_valid_in && !rx_busy_q;
	wire rx_acked   = rxa_s2_q ^ rxa_s3_q;
	wire rx_arrived = rx_s2_q ^ rx_s3_q;

	assign rx_ready_out = !rx_busy_q;

	// Core side holds one byte until the peripheral side has it
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rx_busy_q <= 1'b0;
			rx_hold_q <= IDC_BYTE_RESET;
			rx_tgl_q  <= 1'b0;
			rxa_s1_q  <= 1'b0;
			rxa_s2_q  <= 1'b0;
			rxa_s3_q  <= 1'b0;
		end else begin
			rxa_s1_q <= rx_ack_tgl_q;
			rxa_s2_q <= rxa_s1_q;
			rxa_s3_q <= rxa_s2_q;
			if (rx_take) begin
				rx_busy_q <= 1'b1;
				rx_hold_q <= rx_data_in;
				rx_tgl_q  <= ~rx_tgl_q;
			end else if (rx_acked) begin
				rx_busy_q <= 1'b0;
			end
		end
	end

	// Peripheral side; an unread byte is overwritten by a newer one
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rx_s1_q      <= 1'b0;
			rx_s2_q      <= 1'b0;
			rx_s3_q      <= 1'b0;
			rx_byte_q    <= IDC_BYTE_RESET;
			rx_full_q    <= 1'b0;
			rx_ack_tgl_q <= 1'b0;
		end else begin
			rx_s1_q <= rx_tgl_q;
			rx_s2_q <= rx_s1_q;
			rx_s3_q <= rx_s2_q;
			if (rx_arrived) begin
				rx_byte_q    <= rx_hold_q; // RULE1
				rx_ack_tgl_q <= ~rx_ack_tgl_q;
			end
			// Arrival wins over a read in the same cycle
			if (rx_arrived)   rx_full_q <= 1'b1;
			else if (rd_data) rx_full_q <= 1'b0; // RULE1
		end
	end

	// ------------------------------------------------------------
	// SCL high count toward the core clock
	// ------------------------------------------------------------
	logic en_s1_q;
	logic en_s2_q;
	logic [IDC_HCNT_W-1:0] hcnt_core_q;

	// Count can only change while disabled, so it is sampled then and
	// frozen once enable is seen; the engine is idle while disabled
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			en_s1_q     <= 1'b0;
			en_s2_q     <= 1'b0;
			hcnt_core_q <= IDC_HCNT_RESET;
		end else begin
			en_s1_q <= iface_enable_in;
			en_s2_q <= en_s1_q;
			if (!en_s2_q) hcnt_core_q <= hcnt_q; // RULE9
		end
	end

	assign scl_high_count_out = hcnt_core_q;

endmodule // idc_data_cmd

// >>> hw/idc_pkg.sv
package idc_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam int          IDC_ADDR_W        = 8;
	localparam logic [7:0]  IDC_OFS_DATA_CMD  = 8'h10;
	localparam logic [7:0]  IDC_OFS_SCL_HIGH  = 8'h14;

	// ------------------------------------------------------------
	// Field layout of the data/command port
	// ------------------------------------------------------------
	localparam int          IDC_DATA_LSB      = 0;
	localparam int          IDC_DATA_MSB      = 7;
	localparam int          IDC_DIR_BIT       = 8;
	localparam int          IDC_STOP_BIT      = 9;
	localparam logic [0:0]  IDC_DIR_WRITE     = 1'h0;
	localparam logic [0:0]  IDC_DIR_READ      = 1'h1;

	// ------------------------------------------------------------
	// Standard-speed SCL high count
	// ------------------------------------------------------------
	localparam int          IDC_HCNT_W        = 14;
	localparam logic [13:0] IDC_HCNT_RESET    = 14'h0190;
	localparam logic [13:0] IDC_HCNT_MIN      = 14'h0006;

	// ------------------------------------------------------------
	// Queue and crossing
	// ------------------------------------------------------------
	localparam int          IDC_QUEUE_DEPTH   = 8;
	localparam logic [7:0]  IDC_BYTE_RESET    = 8'h00;

	// One queued command: stop request, direction, data byte
	typedef struct packed {
		logic       stop;
		logic       dir;
		logic [7:0] data;
	} idc_cmd_t;

	localparam int          IDC_CMD_W         = $bits(idc_cmd_t);

	// Drain side of the queue
	typedef enum logic [1:0] {
		IDC_XF_IDLE = 2'b01,
		IDC_XF_WAIT = 2'b10
	} idc_xfer_state_t;

endpackage : idc_pkg

// >>> hw/idc_fifo.sv
`timescale 1ns/10ps

// Small synchronous FIFO; head word is presented from a register
module idc_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic             clk_in,
	input  wire logic             nrst_in,
	// Fill side
	input  wire logic             s_valid_in,
	input  wire logic [WIDTH-1:0] s_data_in,
	output logic                  s_ready_out,
	// Drain side
	output logic                  m_valid_out,
	output logic [WIDTH-1:0]      m_data_out,
	input  wire logic             m_ready_in
);

	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0]    wr_ptr_q;
	logic [PW-1:0]    rd_ptr_q;
	logic [PW:0]      count_q;
	logic             out_valid_q;
	logic [WIDTH-1:0] out_data_q;

	wire              full    = (count_q == (PW+1)'(DEPTH));
	wire              empty   = (count_q == '0);
	wire              push    = s_valid_in && !full;
	wire              out_free = !out_valid_q || m_ready_in;
	wire              pop     = !empty && out_free;

	assign s_ready_out = !full;
	assign m_valid_out = out_valid_q;
	assign m_data_out  = out_data_q;

	// Storage array, no reset needed
	always_ff @(posedge clk_in) begin
		if (push) begin
			mem_q[wr_ptr_q] <= s_data_in;
		end
	end

	// Pointers and fill level
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q  <= '0;
		end else begin
			if (push) wr_ptr_q <= (wr_ptr_q == PW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
			if (pop)  rd_ptr_q <= (rd_ptr_q == PW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
			count_q <= count_q + (PW+1)'(push) - (PW+1)'(pop);
		end
	end

	// Registered head word
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			out_valid_q <= 1'b0;
			out_data_q  <= '0;
		end else if (out_free) begin
			out_valid_q <= pop;
			if (pop) out_data_q <= mem_q[rd_ptr_q];
		end
	end

endmodule // idc_fifo

// >>> dv/idc_monitor.sv
`timescale 1ns/10ps

// Port-level checker for the data/command port and SCL high count
module idc_monitor
	import idc_pkg::*;
(
	// Clocks and reset
	input wire logic                  clk_in,
	input wire logic                  nrst_in,
	input wire logic                  core_clk_in,
	// Register port
	input wire logic                  pwrite_in,
	input wire logic [IDC_ADDR_W-1:0] paddr_in,
	input wire logic [31:0]           pwdata_in,
	input wire logic [31:0]           prdata_out,
	input wire logic                  pready_out,
	input wire logic                  pslverr_out,
	input wire logic                  transmit_abort_flag_out,
	// Core side
	input wire logic                  cmd_valid_out,
	input wire idc_cmd_t              cmd_out,
	input wire logic                  cmd_ready_in,
	input wire logic                  rx_valid_in,
	input wire logic                  rx_ready_out,
	input wire logic [IDC_HCNT_W-1:0] scl_high_count_out
);
	scl_read_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		pready_out && !pwrite_in && paddr_in == IDC_OFS_SCL_HIGH |->
		prdata_out[31:14] == 18'h0 && prdata_out[13:0] >= IDC_HCNT_MIN) else $error("bad count readback");
	data_read_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		pready_out && !pwrite_in && paddr_in == IDC_OFS_DATA_CMD |->
		prdata_out[31:10] == 22'h0 && !prdata_out[8]) else $error("bad data port readback");
	err_map_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		pready_out && pslverr_out |-> paddr_in != IDC_OFS_DATA_CMD && paddr_in != IDC_OFS_SCL_HIGH
		&& prdata_out == 32'h0) else $error("error on mapped address");
	ready_pulse_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		pready_out |=> !pready_out) else $error("ready longer than one cycle");
	abort_cause_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		transmit_abort_flag_out |-> pready_out && pwrite_in && paddr_in == IDC_OFS_DATA_CMD
		&& pwdata_in[IDC_DIR_BIT]) else $error("abort without read command");
	abort_pulse_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
		transmit_abort_flag_out |=> !transmit_abort_flag_out) else $error("abort not a pulse");
	cmd_hold_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		cmd_valid_out && !cmd_ready_in |=> cmd_valid_out && $stable(cmd_out)) else $error("command dropped");
	rx_take_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		rx_valid_in && rx_ready_out |=> !rx_ready_out) else $error("rx ready stayed up");
	hcnt_min_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		scl_high_count_out >= IDC_HCNT_MIN) else $error("count below minimum");
endmodule // idc_monitor

// >>> dv/idc_engine_model.sv
`timescale 1ns/10ps

// Bus engine stand-in on the core clock: logs commands, hands in bytes
module idc_engine_model
	import idc_pkg::*;
(
	// Core clock and reset
	input  wire logic     core_clk_in,
	input  wire logic     nrst_in,
	input  wire logic     stall_in,
	// Command side
	input  wire logic     cmd_valid_in,
	input  wire idc_cmd_t cmd_in,
	output logic          cmd_ready_out,
	// Received byte side
	output logic          rx_valid_out,
	output logic [7:0]    rx_data_out,
	input  wire logic     rx_ready_in
);
	idc_cmd_t got[$];

	initial begin
		rx_valid_out = 1'b0;
		rx_data_out  = 8'hA5;
	end

	// Ready lags the stall request, so slow answers are exercised too
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cmd_ready_out <= 1'b0;
		end else begin
			cmd_ready_out <= !stall_in;
		end
	end

	// Taken words are logged in arrival order
	always @(posedge core_clk_in) begin
		if (nrst_in && cmd_valid_in && cmd_ready_out) begin
			got.push_back(cmd_in);
		end
	end

	// One byte, held until ready is sampled high
	task automatic send(input logic [7:0] b);
		int n = 0;
		@(posedge core_clk_in);
		rx_valid_out <= 1'b1;
		rx_data_out  <= b;
		do begin
			@(posedge core_clk_in);
			n++;
		end while (rx_ready_in !== 1'b1 && n < 200);
		if (n >= 200) testbench.fail_count++;
		rx_valid_out <= 1'b0;
		rx_data_out  <= ~b; // Released line never shows a stale copy
	endtask
endmodule // idc_engine_model

// >>> dv/testbench.sv
`timescale 1ns/10ps

module testbench;
	import idc_pkg::*;
	logic        clk_in, core_clk_in, nrst_in, psel_in, penable_in, pwrite_in;
	logic [7:0]  paddr_in, rx_data_in;
	logic [31:0] pwdata_in, prdata_out, rdata;
	logic        pready_out, pslverr_out, rerr, rabort, stall, en_in, gce_in, gcs_in, mst_in, stx_in, rrq_in;
	logic        abort_out, rxr_out, cmd_valid_out, cmd_ready_in, rx_valid_in, rx_ready_out;
	idc_cmd_t    cmd_out;
	logic [13:0] hcnt_out;
	int          fail_count, tests_run, n;

	idc_data_cmd #(.QUEUE_DEPTH(IDC_QUEUE_DEPTH)) i_dut (.clk_in(clk_in), .nrst_in(nrst_in),
		.psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
		.pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
		.iface_enable_in(en_in), .general_call_enable_in(gce_in), .general_call_sent_in(gcs_in),
		.master_mode_in(mst_in), .slave_transmit_in(stx_in), .slave_read_request_flag_in(rrq_in),
		.transmit_abort_flag_out(abort_out), .rx_byte_ready_out(rxr_out), .core_clk_in(core_clk_in),
		.cmd_valid_out(cmd_valid_out), .cmd_out(cmd_out), .cmd_ready_in(cmd_ready_in),
		.rx_valid_in(rx_valid_in), .rx_data_in(rx_data_in), .rx_ready_out(rx_ready_out),
		.scl_high_count_out(hcnt_out));

	idc_engine_model i_model (.core_clk_in(core_clk_in), .nrst_in(nrst_in), .stall_in(stall),
		.cmd_valid_in(cmd_valid_out), .cmd_in(cmd_out), .cmd_ready_out(cmd_ready_in),
		.rx_valid_out(rx_valid_in), .rx_data_out(rx_data_in), .rx_ready_in(rx_ready_out));

	// Two unrelated clocks: 20 ns peripheral, 32 ns core
	initial begin
		clk_in = 1'b0;
		forever #10 clk_in = ~clk_in;
	end
	initial begin
		core_clk_in = 1'b0;
		#7;
		forever #16 core_clk_in = ~core_clk_in;
	end

	// ----------------------------------------------------------
	// Shared helpers
	// ----------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Request held from setup until ready is sampled high
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k = 0;
		@(negedge clk_in);
		psel_in   = 1'b1;
		pwrite_in = w;
		paddr_in  = a;
		pwdata_in = d;
		@(negedge clk_in);
		penable_in = 1'b1;
		do begin
			@(posedge clk_in);
			k++;
		end while (pready_out !== 1'b1 && k < 2000);
		rdata = prdata_out;
		rerr  = pslverr_out;
		// Abort pulse stands with the answer only
		rabort = abort_out;
		if (k >= 2000) fail_count++;
		@(negedge clk_in);
		psel_in    = 1'b0;
		penable_in = 1'b0;
	endtask

	task automatic wait_got(input int m);
		int k = 0;
		while (i_model.got.size() < m && k < 3000) begin
			@(negedge clk_in);
			k++;
		end
		if (k >= 3000) fail_count++;
	endtask

	// ----------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------
	task automatic t_reset;
		bus(1'b0, IDC_OFS_SCL_HIGH, 32'h0);
		chk(rdata, 32'h0000_0190);
		chk(hcnt_out, 32'h0000_0190);
		bus(1'b0, IDC_OFS_DATA_CMD, 32'h0);
		chk(rdata, 32'h0);
	endtask

	// Count is set before any command goes out, as software must
	task automatic t_hcnt;
		logic [31:0] wv[4] = '{32'hFFFF_C003, 32'h0000_0005, 32'h0000_0006, 32'h0000_2ABC};
		logic [31:0] ev[4] = '{32'h6, 32'h6, 32'h6, 32'h2ABC};
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, IDC_OFS_SCL_HIGH, wv[i]);
			bus(1'b0, IDC_OFS_SCL_HIGH, 32'h0);
			chk(rdata, ev[i]);
		end
		repeat (20) @(negedge clk_in);
		chk(hcnt_out, 32'h2ABC);
		en_in = 1'b1;
		bus(1'b1, IDC_OFS_SCL_HIGH, 32'h100);
		bus(1'b0, IDC_OFS_SCL_HIGH, 32'h0);
		chk(rdata, 32'h2ABC);
		en_in = 1'b0;
	endtask

	task automatic t_cmds;
		mst_in = 1'b1;
		bus(1'b1, IDC_OFS_DATA_CMD, 32'h0A5);
		bus(1'b1, IDC_OFS_DATA_CMD, 32'h13C);
		bus(1'b1, IDC_OFS_DATA_CMD, 32'h2FF);
		bus(1'b1, IDC_OFS_DATA_CMD, 32'h300);
		wait_got(4);
		chk(i_model.got.size(), 4);
		chk(i_model.got[0], 32'h0A5);
		chk(i_model.got[1], 32'h13C);
		chk(i_model.got[2], 32'h2FF);
		chk(i_model.got[3], 32'h300);
		bus(1'b0, IDC_OFS_DATA_CMD, 32'h0);
		chk(rdata, 32'h200);
		i_model.got.delete();
		mst_in = 1'b0;
		stx_in = 1'b1;
		bus(1'b1, IDC_OFS_DATA_CMD, 32'h1C3);
		stx_in = 1'b0;
		bus(1'b1, IDC_OFS_DATA_CMD, 32'h1D4);
		wait_got(2);
		chk(i_model.got[0], 32'h0C3);
		chk(i_model.got[1], 32'h0D4);
		i_model.got.delete();
	endtask

	task automatic t_abort;
		mst_in = 1'b1;
		gce_in = 1'b1;
		gcs_in = 1'b1;
		bus(1'b1, IDC_OFS_DATA_CMD, 32'h111);
		chk(rabort, 1'b1);
		gce_in = 1'b0;
		bus(1'b1, IDC_OFS_DATA_CMD, 32'h122);
		chk(rabort, 1'b0);
		gcs_in = 1'b0;
		mst_in = 1'b0;
		rrq_in = 1'b1;
		bus(1'b1, IDC_OFS_DATA_CMD, 32'h133);
		chk(rabort, 1'b1);
		bus(1'b1, IDC_OFS_DATA_CMD, 32'h044);
		rrq_in = 1'b0;
		wait_got(2);
		repeat (100) @(negedge clk_in);
		chk(i_model.got.size(), 2);
		chk(i_model.got[0], 32'h122);
		chk(i_model.got[1], 32'h044);
		i_model.got.delete();
	endtask

	task automatic t_rx;
		logic [7:0] bv[2] = '{8'h5A, 8'hA5};
		int k;
		foreach (bv[i]) begin
			i_model.send(bv[i]);
			k = 0;
			while (rxr_out !== 1'b1 && k < 100) begin
				@(negedge clk_in);
				k++;
			end
			if (k >= 100) fail_count++;
			bus(1'b0, IDC_OFS_DATA_CMD, 32'h0);
			chk(rdata[7:0], bv[i]);
			chk(rxr_out, 1'b0);
		end
	endtask

	// Engine stalls for 420 cycles while the queue fills and refuses, then drains it in order
	task automatic t_fill;
		mst_in = 1'b1;
		stall  = 1'b1;
		n      = 0;
		repeat (20) @(negedge clk_in);
		fork
			for (int i = 0; i < 16; i++) begin
				bus(1'b1, IDC_OFS_DATA_CMD, i);
				n++;
			end
			begin
				repeat (400) @(negedge clk_in);
				chk(n < 16, 1'b1);
				stall = 1'b0;
			end
		join
		wait_got(16);
		for (int i = 0; i < 16; i++) begin
			chk(i_model.got[i], i);
		end
	endtask

	task automatic t_unmap;
		bus(1'b1, 8'h18, 32'hFFFF_FFFF);
		chk(rerr, 1'b1);
		bus(1'b0, 8'h18, 32'h0);
		chk(rdata, 32'h0);
	endtask

	task automatic end_of_test;
		$display("checks run %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		{psel_in, penable_in, pwrite_in, en_in, gce_in, gcs_in, mst_in, stx_in, rrq_in, stall} = '0;
		paddr_in  = 8'h00;
		pwdata_in = 32'h0;
		nrst_in   = 1'b0;
		repeat (3) @(negedge clk_in);
		nrst_in = 1'b1;
		t_reset;
		t_hcnt;
		t_cmds;
		t_abort;
		t_rx;
		t_fill;
		t_unmap;
		end_of_test;
	end

	// Watchdog well beyond the expected few thousand cycles
	initial begin
		repeat (60000) @(posedge clk_in);
		fail_count++;
		end_of_test;
	end
endmodule // testbench

bind idc_data_cmd idc_monitor i_mon (.clk_in(clk_in), .nrst_in(nrst_in), .core_clk_in(core_clk_in),
	.pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
	.pready_out(pready_out), .pslverr_out(pslverr_out), .transmit_abort_flag_out(transmit_abort_flag_out),
	.cmd_valid_out(cmd_valid_out), .cmd_out(cmd_out), .cmd_ready_in(cmd_ready_in),
	.rx_valid_in(rx_valid_in), .rx_ready_out(rx_ready_out), .scl_high_count_out(scl_high_count_out));
